/* File: lsc_top.sv */
// Summary of operation
// R1: Tone comes from the internal divider, fixed at 22kHz, no trimming needed.
// R2: Converter clock runs at ten times the tone rate, same divider.
// R3: Tone force bit low: tone follows the synchronised modulation input.
// R4: Tone force bit high: continuous tone, modulation input ignored.
// R5: Host keeps tone force low while burst coding on the modulation pin.
// R6: Output enable low shuts the converter power block down.
// R7: Enabled output targets 13V with select low, 18V with select high.
// R8: Cable drop boost bit adds 1V to the selected target.
// R9: Current select low picks the 425mA limit, high the 775mA limit.
// R10: Dynamic mode overload turns output off 900ms and sets overload flag.
// R11: After off time, output returns 20ms with current clamped.
// R12: Overload during or at end of on time repeats off then on.
// R13: A clean full on interval resumes normal operation, clears flag.
// R14: Off plus on retry period totals about 920ms from internal timer.
// R15: Host may start in static mode for capacitive loads, then go dynamic.
// R16: Static mode overload flag follows the sensed overload level.
// R17: Overload flag reads low after power-on start-up.
// R18: Overtemperature shuts converter and regulator, sets overtemp flag.
// R19: Overtemperature release restores operation, clears overtemp flag.
// R20: Register at 13V: external pin low gives 13V, high gives 18V.
// R21: Host using the external pin leaves register select at 13V.
// R22: Control registers read back, two bits report diagnostic status.
// R23: All control and status bits clear to zero at reset.
// R24: Overload and overtemp flags are read-only to host writes.
// R25: Overload, overtemp and modulation inputs pass two-flop synchronisers.
// R26: Retry intervals count converter clock periods.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lsc_top
  import lsc_pkg::*;
#(
  parameter int unsigned ADDR_W      = 4,
  parameter int unsigned RETRY_W     = 18,
  parameter int unsigned OFF_COUNT   = OFF_PERIODS,
  parameter int unsigned ON_COUNT    = ON_PERIODS
)(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [7:0]        wb_dat_i,
  input  wire logic              wb_sel_i,
  output logic      [7:0]        wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              overload_i,
  input  wire logic              overtemp_i,
  input  wire logic              tone_modulation_in_i,
  input  wire logic              ext_high_voltage_pin_i,
  output logic                   tone_o,
  output logic                   conv_clk_o,
  output logic                   power_en_o,
  output logic      [4:0]        target_volts_o,
  output logic                   current_limit_high_o,
  output logic                   current_clamp_o
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] in_meta_reg;
  logic [2:0] in_sync_reg;
  logic       ovl_sync;
  logic       ot_sync;
  logic       mod_sync;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_meta_reg <= 3'h0;
      in_sync_reg <= 3'h0;
    end
    else
    begin
      in_meta_reg <= {tone_modulation_in_i, overtemp_i, overload_i}; // R25
      in_sync_reg <= in_meta_reg;
    end
  end

  assign ovl_sync = in_sync_reg[0];
  assign ot_sync  = in_sync_reg[1];
  assign mod_sync = in_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  lsc_ctrl_t ctrl_reg;
  lsc_ctrl_t ctrl_next;
  logic      ack_reg;
  logic      ack_next;
  logic [7:0] dat_reg;
  logic [7:0] dat_next;
  logic      olf_reg;
  logic      otf_reg;

  always_comb
  begin
    ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
    ctrl_next = ctrl_reg;
    dat_next  = dat_reg;
    // Write lands on the edge at which the master samples ack
    // Flag bit is not stored from the bus
    if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i
        && wb_adr_i == ADDR_W'(CTRL_ADDR))
      ctrl_next = lsc_ctrl_t'(wb_dat_i[7:CTRL_LSB]); // R24
    if (ack_next)
    begin
      if (wb_adr_i == ADDR_W'(CTRL_ADDR))
      begin
        dat_next = 8'h00;
        dat_next[7:CTRL_LSB] = ctrl_reg; // R22
        dat_next[OLF_BIT] = olf_reg;
      end
      else if (wb_adr_i == ADDR_W'(THERM_ADDR))
      begin
        dat_next = 8'h00;
        dat_next[OTF_BIT] = otf_reg; // R22
      end
      else
        dat_next = 8'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RST; // R23
      ack_reg  <= 1'b0;
      dat_reg  <= 8'h00;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      ack_reg  <= ack_next;
      dat_reg  <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////
  // Oscillator: converter clock and tone from one divider
  localparam int unsigned HALF_W = $clog2(HALF_CYC + 1);
  localparam int unsigned STEP_W = $clog2(TONE_HALF_STEPS + 1);

  logic [HALF_W-1:0] half_cnt_reg;
  logic [HALF_W-1:0] half_cnt_next;
  logic [STEP_W-1:0] step_reg;
  logic [STEP_W-1:0] step_next;
  logic              conv_reg;
  logic              conv_next;
  logic              phase_reg;
  logic              phase_next;
  logic              half_tick;
  logic              period_tick;

  always_comb
  begin
    half_tick     = (half_cnt_reg == HALF_W'(HALF_CYC - 1));
    half_cnt_next = half_tick ? '0 : half_cnt_reg + 1'b1;
    conv_next     = conv_reg ^ half_tick; // R2
    step_next     = step_reg;
    phase_next    = phase_reg;
    if (half_tick)
    begin
      if (step_reg == STEP_W'(TONE_HALF_STEPS - 1))
      begin
        step_next  = '0;
        phase_next = ~phase_reg; // R1
      end
      else
        step_next = step_reg + 1'b1;
    end
    // One tick per full converter period
    period_tick = half_tick & conv_reg; // R26
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_cnt_reg <= '0;
      step_reg     <= '0;
      conv_reg     <= 1'b0;
      phase_reg    <= 1'b0;
    end
    else
    begin
      half_cnt_reg <= half_cnt_next;
      step_reg     <= step_next;
      conv_reg     <= conv_next;
      phase_reg    <= phase_next;
    end
  end

  assign conv_clk_o = conv_reg;

  ////////////////////////////////////////////////////////////////////////
  // Overload protection and flags
  lsc_state_t         state_reg;
  lsc_state_t         state_next;
  logic [RETRY_W-1:0] cnt_reg;
  logic [RETRY_W-1:0] cnt_next;
  logic               seen_reg;
  logic               seen_next;
  logic               olf_next;
  logic               otf_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    seen_next  = seen_reg;
    olf_next   = olf_reg;
    otf_next   = ot_sync; // R18 R19
    if (!ctrl_reg.output_enable)
    begin
      // Disabled output holds no retry history
      state_next = ST_NORMAL;
      olf_next   = 1'b0; // R17
    end
    else if (ctrl_reg.static_limit_select)
    begin
      state_next = ST_NORMAL;
      olf_next   = ovl_sync; // R16
    end
    else
    begin
      case (state_reg)
        ST_NORMAL:
        begin
          if (ovl_sync)
          begin
            state_next = ST_OFF; // R10
            cnt_next   = RETRY_W'(OFF_COUNT - 1);
            olf_next   = 1'b1; // R10
          end
        end
        ST_OFF:
        begin
          if (period_tick)
          begin
            if (cnt_reg == '0)
            begin
              state_next = ST_ON; // R11
              cnt_next   = RETRY_W'(ON_COUNT - 1);
              seen_next  = 1'b0;
            end
            else
              cnt_next = cnt_reg - 1'b1; // R14
          end
        end
        ST_ON:
        begin
          seen_next = seen_reg | ovl_sync;
          if (period_tick)
          begin
            if (cnt_reg == '0)
            begin
              if (seen_reg || ovl_sync)
              begin
                state_next = ST_OFF; // R12
                cnt_next   = RETRY_W'(OFF_COUNT - 1);
              end
              else
              begin
                state_next = ST_NORMAL; // R13
                olf_next   = 1'b0; // R13
              end
            end
            else
              cnt_next = cnt_reg - 1'b1;
          end
        end
        default:
          state_next = ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_NORMAL;
      cnt_reg   <= '0;
      seen_reg  <= 1'b0;
      olf_reg   <= 1'b0; // R23
      otf_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      seen_reg  <= seen_next;
      olf_reg   <= olf_next;
      otf_reg   <= otf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power stage outputs
  logic       power_reg;
  logic       power_next;
  logic       tone_reg;
  logic       tone_next;
  logic [4:0] volts_reg;
  logic [4:0] volts_next;
  logic       ilim_reg;
  logic       ilim_next;
  logic       clamp_reg;
  logic       clamp_next;
  logic       high_sel;

  always_comb
  begin
    // Converter and regulator share one enable
    power_next = ctrl_reg.output_enable & ~ot_sync & (state_reg != ST_OFF); // R6 R18
    // Pin acts only while register selects the low voltage
    high_sel   = ctrl_reg.high_voltage_select | ext_high_voltage_pin_i; // R20
    volts_next = high_sel ? V_HIGH : V_LOW; // R7
    if (ctrl_reg.cable_drop_boost)
      volts_next = volts_next + V_STEP; // R8
    ilim_next  = ctrl_reg.current_limit_high; // R9
    clamp_next = (state_reg == ST_ON); // R11
    tone_next  = phase_reg & power_next
                 & (ctrl_reg.tone_force_on | mod_sync); // R3 R4
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_reg <= 1'b0;
      tone_reg  <= 1'b0;
      volts_reg <= V_LOW;
      ilim_reg  <= 1'b0;
      clamp_reg <= 1'b0;
    end
    else
    begin
      power_reg <= power_next;
      tone_reg  <= tone_next;
      volts_reg <= volts_next;
      ilim_reg  <= ilim_next;
      clamp_reg <= clamp_next;
    end
  end

  assign power_en_o           = power_reg;
  assign tone_o               = tone_reg;
  assign target_volts_o       = volts_reg;
  assign current_limit_high_o = ilim_reg;
  assign current_clamp_o      = clamp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_bus_ack_drop: assert property (wb_ack_o |=> !wb_ack_o) // R22
    else $error("ack held two cycles");

  a_conv_half_period: assert property
    ($changed(conv_clk_o) |-> ##45 $changed(conv_clk_o)) // R2
    else $error("converter clock half period wrong");

  a_tone_forced_on: assert property
    (ctrl_reg.tone_force_on && power_next && phase_reg |=> tone_o) // R4
    else $error("forced tone missing");

  a_tone_pin_gate: assert property
    (!ctrl_reg.tone_force_on && !mod_sync |=> !tone_o) // R3
    else $error("tone present without modulation");

  a_shutdown_power: assert property
    (!ctrl_reg.output_enable |=> !power_en_o) // R6
    else $error("power on while disabled");

  a_volts_select: assert property
    (!ctrl_reg.high_voltage_select && !ext_high_voltage_pin_i
     && !ctrl_reg.cable_drop_boost |=> target_volts_o == V_LOW) // R7 R20
    else $error("low target wrong");

  a_volts_boost: assert property
    (ctrl_reg.high_voltage_select && ctrl_reg.cable_drop_boost
     |=> target_volts_o == V_HIGH + V_STEP) // R8
    else $error("boost target wrong");

  a_overload_trip: assert property
    (state_reg == ST_NORMAL && ovl_sync && ctrl_reg.output_enable
     && !ctrl_reg.static_limit_select |=> state_reg == ST_OFF && olf_reg) // R10
    else $error("overload did not trip");

  a_off_no_power: assert property
    ((state_reg == ST_OFF)[*2] |-> !power_en_o) // R10
    else $error("power on in off interval");

  a_on_clamped: assert property
    ((state_reg == ST_ON)[*2] |-> current_clamp_o) // R11
    else $error("no clamp in on interval");

  a_static_flag: assert property
    (ctrl_reg.output_enable && ctrl_reg.static_limit_select
     |=> olf_reg == $past(ovl_sync)) // R16
    else $error("static flag mismatch");

  a_overtemp_off: assert property
    (ot_sync |=> otf_reg && !power_en_o) // R18
    else $error("overtemp not handled");

endmodule
`default_nettype wire

/* File: lsc_pkg.sv */
`default_nettype none
package lsc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TONE_HZ         = 22_000;
  localparam int unsigned CONV_MULT       = 10;
  localparam int unsigned CONV_HZ         = TONE_HZ * CONV_MULT;
  // Half period of the converter clock, in system clocks
  localparam int unsigned HALF_CYC        = (CLK_HZ / (2 * CONV_HZ) < 1) ? 1
                                            : CLK_HZ / (2 * CONV_HZ);
  // Converter half periods in one tone half period
  localparam int unsigned TONE_HALF_STEPS = CONV_MULT;
  localparam int unsigned T_CYCLE_MS      = 920;
  localparam int unsigned T_ON_MS         = 20;
  localparam int unsigned T_OFF_MS        = 900;
  // Retry intervals in converter periods
  localparam int unsigned OFF_PERIODS     = T_OFF_MS * (CONV_HZ / 1000);
  localparam int unsigned ON_PERIODS      = T_ON_MS * (CONV_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] CTRL_ADDR  = 4'h0;
  localparam logic [3:0] THERM_ADDR = 4'h4;
  localparam int unsigned CTRL_LSB  = 2;
  localparam int unsigned OLF_BIT   = 0;
  localparam int unsigned OTF_BIT   = 1;

  typedef struct packed {
    logic static_limit_select;
    logic current_limit_high;
    logic tone_force_on;
    logic cable_drop_boost;
    logic high_voltage_select;
    logic output_enable;
  } lsc_ctrl_t;

  localparam lsc_ctrl_t CTRL_RST = '0;

  ////////////////////////////////////////////////////////////////////////
  // Output voltage targets in volts
  localparam logic [4:0] V_LOW  = 5'h0D;
  localparam logic [4:0] V_HIGH = 5'h12;
  localparam logic [4:0] V_STEP = 5'h01;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_OFF    = 2'b01,
    ST_ON     = 2'b11
  } lsc_state_t;

endpackage
`default_nettype wire

/* File: lsc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Host side of the register bus: classic single-cycle master
module lsc_host (
  input  wire logic       clk_i,
  input  wire logic       ack_i,
  input  wire logic [7:0] dat_i,
  output logic            cyc_o,
  output logic            stb_o,
  output logic            we_o,
  output logic [3:0]      adr_o,
  output logic [7:0]      dat_o,
  output logic            sel_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 4'h0;
    dat_o = 8'h00;
    sel_o = 1'b0;
  end

  // Unknown data on timeout so the caller's compare fails
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_i !== 1'b1 && n < 20);
    q = (n < 20) ? dat_i : 8'hXX;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lsc_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       ovl   = 1'b0;
  logic       otmp  = 1'b0;
  logic       mdl   = 1'b0;
  logic       pin   = 1'b0;
  logic       cyc, stb, we, sel, ack, tone, conv, pwr, ilim, clamp, mon;
  logic [3:0] adr;
  logic [7:0] wd, rd;
  logic [4:0] volts;
  logic [1:0] msel = 2'd0;
  int         n_errors = 0;
  int         n_checks = 0;
  int         n;

  assign mon = (msel == 2'd0) ? tone : (msel == 2'd1) ? conv : (msel == 2'd2) ? pwr : clamp;
  always #25 clk_i = ~clk_i;

  // Short retry counts: off 3, on 2 converter periods
  lsc_top #(.OFF_COUNT(3), .ON_COUNT(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack),
    .overload_i(ovl), .overtemp_i(otmp), .tone_modulation_in_i(mdl),
    .ext_high_voltage_pin_i(pin), .tone_o(tone), .conv_clk_o(conv),
    .power_en_o(pwr), .target_volts_o(volts), .current_limit_high_o(ilim),
    .current_clamp_o(clamp));
  lsc_host u_host (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .dat_o(wd), .sel_o(sel));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b1, a, d, q);
    // Unknown data means the write timed out
    chk({7'h00, q === 8'hXX}, 8'h00);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Clocks until the selected output reaches v, capped at lim
  task automatic wt(input logic [1:0] s, input logic v, input int lim, output int c);
    msel = s;
    #1;
    c = 0;
    while (mon !== v && c < lim)
    begin
      @(posedge clk_i);
      #1;
      c++;
    end
  endtask
  function automatic logic [7:0] inr(input int c, input int a, input int b);
    return {7'h00, (c >= a && c <= b)};
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(30000 * 50);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(CTRL_ADDR, 8'h00);
    rdc(THERM_ADDR, 8'h00);
    chk({3'b000, volts}, {3'b000, V_LOW});
    wr(CTRL_ADDR, 8'hFF);
    rdc(CTRL_ADDR, 8'hFC);
    wr(THERM_ADDR, 8'hFF);
    rdc(THERM_ADDR, 8'h00);
    rdc(4'h8, 8'h00);
    wr(CTRL_ADDR, 8'h00);
    cyc_n(2);
    chk({7'h00, pwr}, 8'h00);
    $display("registers done");

    for (int i = 0; i < 4; i++)
    begin
      wr(CTRL_ADDR, {1'b0, i[0], 1'b0, i[1], i[0], 1'b1, 2'b00});
      cyc_n(2);
      chk({3'b000, volts}, {3'b000, (i[0] ? V_HIGH : V_LOW) + (i[1] ? V_STEP : 5'h00)});
      chk({7'h00, ilim}, {7'h00, i[0]});
      chk({7'h00, pwr}, 8'h01);
      rdc(CTRL_ADDR, {1'b0, i[0], 1'b0, i[1], i[0], 1'b1, 2'b00});
    end
    wr(CTRL_ADDR, 8'h04);
    pin <= 1'b1;
    cyc_n(3);
    chk({3'b000, volts}, {3'b000, V_HIGH});
    @(posedge clk_i) pin <= 1'b0;
    cyc_n(3);
    chk({3'b000, volts}, {3'b000, V_LOW});
    $display("voltage done");

    // Force bit low while the pin gates the tone
    wt(2'd0, 1'b1, 1000, n);
    chk(inr(n, 1000, 1000), 8'h01);
    @(posedge clk_i) mdl <= 1'b1;
    wt(2'd0, 1'b1, 1000, n);
    chk(inr(n, 0, 999), 8'h01);
    // First burst may start mid-phase, so time a later one
    wt(2'd0, 1'b0, 1000, n);
    wt(2'd0, 1'b1, 1000, n);
    wt(2'd0, 1'b0, 1000, n);
    chk(inr(n, 449, 451), 8'h01);
    @(posedge clk_i) mdl <= 1'b0;
    wr(CTRL_ADDR, 8'h24);
    wt(2'd0, 1'b1, 1000, n);
    wt(2'd0, 1'b0, 1000, n);
    chk(inr(n, 449, 451), 8'h01);
    wt(2'd1, 1'b0, 100, n);
    wt(2'd1, 1'b1, 100, n);
    wt(2'd1, 1'b0, 100, n);
    chk(inr(n, 44, 46), 8'h01);
    $display("tone done");

    wr(CTRL_ADDR, 8'h04);
    otmp <= 1'b1;
    cyc_n(6);
    chk({7'h00, pwr}, 8'h00);
    rdc(THERM_ADDR, 8'h02);
    otmp <= 1'b0;
    cyc_n(6);
    chk({7'h00, pwr}, 8'h01);
    rdc(THERM_ADDR, 8'h00);
    $display("thermal done");

    // Static first, then dynamic, as for a capacitive load
    wr(CTRL_ADDR, 8'h84);
    ovl <= 1'b1;
    cyc_n(6);
    rdc(CTRL_ADDR, 8'h85);
    chk({7'h00, pwr}, 8'h01);
    @(posedge clk_i) ovl <= 1'b0;
    cyc_n(6);
    rdc(CTRL_ADDR, 8'h84);
    wr(CTRL_ADDR, 8'h04);
    ovl <= 1'b1;
    wt(2'd2, 1'b0, 20, n);
    chk(inr(n, 0, 8), 8'h01);
    rdc(CTRL_ADDR, 8'h05);
    wt(2'd2, 1'b1, 400, n);
    chk(inr(n, 175, 285), 8'h01);
    chk({7'h00, clamp}, 8'h01);
    wt(2'd2, 1'b0, 300, n);
    chk(inr(n, 0, 299), 8'h01);
    @(posedge clk_i) ovl <= 1'b0;
    wt(2'd2, 1'b1, 400, n);
    chk(inr(n, 0, 399), 8'h01);
    wt(2'd3, 1'b0, 300, n);
    chk(inr(n, 85, 195), 8'h01);
    rdc(CTRL_ADDR, 8'h04);
    $display("overload done");
    summarize();
  end
endmodule
`default_nettype wire
